// [rtl/svqc_pkg.sv]
// svqc_pkg: register map, reset values and timing of the switch
// configuration bank; shared by the top, the svqc_sched worker and the bench.
package svqc_pkg;

  // ----------------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL = 8'hAE;
  localparam logic [7:0] IDX_SA1_LOW = 8'hB0;
  localparam logic [7:0] IDX_SA1_MID = 8'hB2;
  localparam logic [7:0] IDX_SA1_HIGH = 8'hB4;
  localparam logic [7:0] IDX_SA2_LOW = 8'hB6;
  localparam logic [7:0] IDX_SA2_MID = 8'hB8;
  localparam logic [7:0] IDX_SA2_HIGH = 8'hBA;
  localparam logic [7:0] IDX_Q32 = 8'hC8;
  localparam logic [7:0] IDX_Q10 = 8'hCA;
  localparam logic [7:0] IDX_STATUS = 8'hF0;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int FWD_LSB = 8;
  localparam int RSV_LSB = 6;
  localparam logic [2:0] FWD_RST = 3'h0;
  localparam logic [1:0] RSV_RST = 2'h0;
  localparam logic [5:0] INS_RST = 6'h00;
  localparam logic [15:0] MAC_WORD_RST = 16'h0000;
  localparam int HI_CTRL_BIT = 15;
  localparam int HI_RATIO_LSB = 8;
  localparam int LO_CTRL_BIT = 7;
  localparam logic [6:0] Q3_RATIO_RST = 7'h08;
  localparam logic [6:0] Q2_RATIO_RST = 7'h04;
  localparam logic [6:0] Q1_RATIO_RST = 7'h02;
  localparam logic [6:0] Q0_RATIO_RST = 7'h01;
  localparam logic QCTRL_RST = 1'b1;
  localparam logic [15:0] Q32_RST =
    {QCTRL_RST, Q2_RATIO_RST, QCTRL_RST, Q3_RATIO_RST};
  localparam logic [15:0] Q10_RST =
    {QCTRL_RST, Q0_RATIO_RST, QCTRL_RST, Q1_RATIO_RST};

  // ----------------------------------------------------------------------
  // scheduling period
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int PERIOD_NS = 10000;
  localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;

endpackage : svqc_pkg

// [rtl/svqc_sched.sv]
// svqc_sched: port 1 transmit queue selector with per-queue packet
// credits. assumes pending flags and take pulses come from clk_sys logic.
`timescale 1ns/100ps
`default_nettype none
module svqc_sched import svqc_pkg::*; #(
  parameter int NQ = 4,
  parameter int RW = 7,
  parameter int PCYC = PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NQ-1:0] ratio_en,
  input wire logic [NQ*RW-1:0] ratio,
  input wire logic [NQ-1:0] pending,
  input wire logic take,
  output logic sel_valid_reg,
  output logic [1:0] sel_q_reg
);
  initial begin
    // the period counter is 16 bits wide
    if (NQ != 4 || RW < 1 || PCYC < 2 || PCYC > 65536) begin
      $error("svqc_sched bad params");
    end
  end

  logic [RW-1:0] credit [NQ];
  logic [15:0] per_cnt;
  logic tick;
  logic [NQ-1:0] elig;
  logic [1:0] pick;

  assign tick = (per_cnt == 16'(PCYC - 1));

  // ----------------------------------------------------------------------
  // period counter
  // ----------------------------------------------------------------------
  // RULE14 fixed period
  always_ff @(posedge clk_sys) begin
    if (rst || tick) per_cnt <= 16'h0000;
    else per_cnt <= per_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // eligibility and priority pick
  // ----------------------------------------------------------------------
  always_comb begin
    pick = 2'h0;
    for (int i = 0; i < NQ; i++) begin
      // RULE8 strict or credit
      elig[i] = pending[i] && (!ratio_en[i] || credit[i] != '0);
    end
    // RULE14 high to low order
    for (int i = 0; i < NQ; i++) begin
      if (elig[i]) pick = 2'(i);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_valid_reg <= 1'b0;
      sel_q_reg <= 2'h0;
    end else begin
      sel_valid_reg <= |elig && !take;
      sel_q_reg <= pick;
    end
  end

  // ----------------------------------------------------------------------
  // credits: reload each period, spend one per packet taken
  // ----------------------------------------------------------------------
  // software ratio changes only land at the next reload, so a period
  // never runs with a half-applied budget
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < NQ; i++) begin
      if (rst || tick) begin
        credit[i] <= ratio[i*RW +: RW];
      end else if (take && sel_valid_reg && sel_q_reg == 2'(i)
                   && ratio_en[i] && credit[i] != '0) begin
        // RULE9 count packets
        credit[i] <= credit[i] - RW'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_STRICT_Q3: assert property ( // RULE8
    @(posedge clk_sys) disable iff (rst)
    (pending[3] && !ratio_en[3] && !take)
      |=> (sel_valid_reg && sel_q_reg == 2'h3)
  ) else $error("strict queue 3 not selected");

  AST_RELOAD: assert property ( // RULE14
    @(posedge clk_sys) disable iff (rst)
    tick |=> (credit[0] == $past(ratio[RW-1:0]))
  ) else $error("credit not reloaded at period");

  AST_NO_CREDIT: assert property ( // RULE9
    @(posedge clk_sys) disable iff (rst)
    (ratio_en[3] && credit[3] == '0 && !tick)
      |=> !(sel_valid_reg && sel_q_reg == 2'h3)
  ) else $error("queue 3 served without credit");
endmodule : svqc_sched
`default_nettype wire

// [rtl/svqc_safilt.sv]
// svqc_safilt: compares a received source address with the two filter
// addresses. assumes sa_valid is a one-cycle strobe on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module svqc_safilt (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [47:0] mac1,
  input wire logic [47:0] mac2,
  input wire logic sa_valid,
  input wire logic [47:0] sa_addr,
  output logic sa_done_reg,
  output logic [1:0] sa_hit_reg
);
  // an all-zero filter address is treated as unprogrammed
  function automatic logic mac_hit(input logic [47:0] a, input logic [47:0] f);
    return (f != 48'h0000_0000_0000) && (a == f);
  endfunction : mac_hit

  // RULE15 compare both
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sa_done_reg <= 1'b0;
      sa_hit_reg <= 2'h0;
    end else begin
      sa_done_reg <= sa_valid;
      sa_hit_reg <= sa_valid ? {mac_hit(sa_addr, mac2), mac_hit(sa_addr, mac1)}
                             : 2'h0;
    end
  end

  AST_SA_MATCH: assert property ( // RULE15
    @(posedge clk_sys) disable iff (rst)
    (sa_valid && mac1 != 48'h0 && sa_addr == mac1)
      |=> (sa_done_reg && sa_hit_reg[0])
  ) else $error("filter address 1 match missed");
endmodule : svqc_safilt
`default_nettype wire

// [rtl/svqc_top.sv]
// svqc_top: switch configuration bank for invalid-VID forwarding, PVID
// tag insertion, source address filters and port 1 queue ratios.
// assumes an Avalon-MM master on clk_sys and forwarding logic on clk_sys.
//
// Functional notes
// RULE1: 3-bit RW invalid-VID forward mask, reset zero.
// RULE2: mask top bit host port, middle port 2, bottom port 1.
// RULE3: set pair enable inserts source PVID tag into untagged frames.
// RULE4: enables: 5 p3-p2, 4 p3-p1, 3 p2-p3, 2 p2-p1, 1 p1-p3, 0 p1-p2.
// RULE5: control bits 15-11 read zero; bits 7-6 reserved storage.
// RULE6: filter address 1 as low, mid, high RW words, reset zero.
// RULE7: filter address 2 likewise, consecutive offsets, reset zero.
// RULE8: queue 3 control clear means strict priority over lower queues.
// RULE9: queue 3 control set limits to 7-bit ratio; ratio resets 8.
// RULE10: queue 2 control bit 15, ratio 14-8 reset 4.
// RULE11: queue 1 control bit 7, ratio 6-0 reset 2.
// RULE12: queue 0 control bit 15, ratio 14-8 reset 1.
// RULE13: all four queue control bits reset to one.
// RULE14: fixed period refills credits; ratio queues served high to low.
// RULE15: source addresses compared with both filter addresses.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module svqc_top import svqc_pkg::*; #(
  parameter int PCYC = PERIOD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bad_vid_valid,
  output logic bad_vid_out_valid,
  output logic [2:0] bad_vid_fwd_mask,
  input wire logic fwd_valid,
  input wire logic [1:0] fwd_src_port,
  input wire logic [1:0] fwd_dst_port,
  input wire logic fwd_untagged,
  output logic fwd_out_valid,
  output logic fwd_insert_tag,
  input wire logic [3:0] txq_pending,
  input wire logic txq_take,
  output logic txq_sel_valid,
  output logic [1:0] txq_sel_queue,
  input wire logic sa_valid,
  input wire logic [47:0] sa_addr,
  output logic sa_done,
  output logic [1:0] sa_hit
);
  initial begin
    if (PCYC < 2) $error("svqc_top PCYC too small");
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction : be_merge

  // port codes 1..3; 0 or same port never inserts
  function automatic logic ins_bit(input logic [5:0] en,
                                   input logic [1:0] s,
                                   input logic [1:0] d);
    logic r;
    r = 1'b0;
    // RULE4 pair mapping
    case ({s, d})
      4'h6: r = en[0];
      4'h7: r = en[1];
      4'h9: r = en[2];
      4'hB: r = en[3];
      4'hD: r = en[4];
      4'hE: r = en[5];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : ins_bit

  // ----------------------------------------------------------------------
  // bus handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------------
  logic req;
  logic ack_reg;
  logic wr_go;

  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_reg;
  assign wr_go = avs_write && ack_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) ack_reg <= 1'b0;
    else ack_reg <= req && !ack_reg;
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [2:0] fwd_mask_reg;
  logic [1:0] rsv_reg;
  logic [5:0] ins_en_reg;
  logic [15:0] sa1_low_reg, sa1_mid_reg, sa1_high_reg;
  logic [15:0] sa2_low_reg, sa2_mid_reg, sa2_high_reg;
  logic [15:0] q32_reg;
  logic [15:0] q10_reg;
  logic [15:0] ctrl_rd;
  logic [15:0] ctrl_next;

  // RULE5 upper bits zero
  assign ctrl_rd = {5'h00, fwd_mask_reg, rsv_reg, ins_en_reg};
  assign ctrl_next = be_merge(ctrl_rd, avs_writedata, avs_byteenable);

  // RULE1 forward mask
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fwd_mask_reg <= FWD_RST;
      rsv_reg <= RSV_RST;
      ins_en_reg <= INS_RST;
    end else if (wr_go && avs_address == byte_addr(IDX_CTRL)) begin
      fwd_mask_reg <= ctrl_next[FWD_LSB +: 3];
      rsv_reg <= ctrl_next[RSV_LSB +: 2];
      ins_en_reg <= ctrl_next[5:0];
    end
  end

  // RULE6 first filter address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sa1_low_reg <= MAC_WORD_RST;
      sa1_mid_reg <= MAC_WORD_RST;
      sa1_high_reg <= MAC_WORD_RST;
    end else if (wr_go) begin
      if (avs_address == byte_addr(IDX_SA1_LOW))
        sa1_low_reg <= be_merge(sa1_low_reg, avs_writedata, avs_byteenable);
      if (avs_address == byte_addr(IDX_SA1_MID))
        sa1_mid_reg <= be_merge(sa1_mid_reg, avs_writedata, avs_byteenable);
      if (avs_address == byte_addr(IDX_SA1_HIGH))
        sa1_high_reg <= be_merge(sa1_high_reg, avs_writedata, avs_byteenable);
    end
  end

  // RULE7 second filter address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sa2_low_reg <= MAC_WORD_RST;
      sa2_mid_reg <= MAC_WORD_RST;
      sa2_high_reg <= MAC_WORD_RST;
    end else if (wr_go) begin
      if (avs_address == byte_addr(IDX_SA2_LOW))
        sa2_low_reg <= be_merge(sa2_low_reg, avs_writedata, avs_byteenable);
      if (avs_address == byte_addr(IDX_SA2_MID))
        sa2_mid_reg <= be_merge(sa2_mid_reg, avs_writedata, avs_byteenable);
      if (avs_address == byte_addr(IDX_SA2_HIGH))
        sa2_high_reg <= be_merge(sa2_high_reg, avs_writedata, avs_byteenable);
    end
  end

  // RULE13 controls reset set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q32_reg <= Q32_RST;
      q10_reg <= Q10_RST;
    end else if (wr_go) begin
      if (avs_address == byte_addr(IDX_Q32))
        q32_reg <= be_merge(q32_reg, avs_writedata, avs_byteenable);
      if (avs_address == byte_addr(IDX_Q10))
        q10_reg <= be_merge(q10_reg, avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------------
  // read path; unmapped addresses read zero and ignore writes
  // ----------------------------------------------------------------------
  logic [15:0] rd_mux;
  logic [15:0] status_rd;
  logic [1:0] sa_last_reg;

  assign status_rd = {11'h000, sa_last_reg, txq_sel_valid, txq_sel_queue};

  always_comb begin
    case (avs_address)
      byte_addr(IDX_CTRL): rd_mux = ctrl_rd;
      byte_addr(IDX_SA1_LOW): rd_mux = sa1_low_reg;
      byte_addr(IDX_SA1_MID): rd_mux = sa1_mid_reg;
      byte_addr(IDX_SA1_HIGH): rd_mux = sa1_high_reg;
      byte_addr(IDX_SA2_LOW): rd_mux = sa2_low_reg;
      byte_addr(IDX_SA2_MID): rd_mux = sa2_mid_reg;
      byte_addr(IDX_SA2_HIGH): rd_mux = sa2_high_reg;
      byte_addr(IDX_Q32): rd_mux = q32_reg;
      byte_addr(IDX_Q10): rd_mux = q10_reg;
      byte_addr(IDX_STATUS): rd_mux = status_rd;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_reg) avs_readdata <= {16'h0000, rd_mux};
  end

  // ----------------------------------------------------------------------
  // invalid-VID forwarding and tag insertion decisions
  // ----------------------------------------------------------------------
  // RULE2 host, port 2, port 1
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bad_vid_out_valid <= 1'b0;
      bad_vid_fwd_mask <= 3'h0;
    end else begin
      bad_vid_out_valid <= bad_vid_valid;
      bad_vid_fwd_mask <= bad_vid_valid ? fwd_mask_reg : 3'h0;
    end
  end

  // RULE3 insert source PVID
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fwd_out_valid <= 1'b0;
      fwd_insert_tag <= 1'b0;
    end else begin
      fwd_out_valid <= fwd_valid;
      fwd_insert_tag <= fwd_valid && fwd_untagged
                        && ins_bit(ins_en_reg, fwd_src_port, fwd_dst_port);
    end
  end

  // ----------------------------------------------------------------------
  // queue scheduler and source filter
  // ----------------------------------------------------------------------
  logic [3:0] q_en;
  logic [27:0] q_ratio;

  // RULE10 queue 2 fields
  // RULE11 queue 1 fields
  // RULE12 queue 0 fields
  assign q_en = {q32_reg[LO_CTRL_BIT], q32_reg[HI_CTRL_BIT],
                 q10_reg[LO_CTRL_BIT], q10_reg[HI_CTRL_BIT]};
  assign q_ratio = {q32_reg[6:0], q32_reg[HI_RATIO_LSB +: 7],
                    q10_reg[6:0], q10_reg[HI_RATIO_LSB +: 7]};

  svqc_sched #(.NQ(4), .RW(7), .PCYC(PCYC)) u_sched (
    .clk_sys(clk_sys),
    .rst(rst),
    .ratio_en(q_en),
    .ratio(q_ratio),
    .pending(txq_pending),
    .take(txq_take),
    .sel_valid_reg(txq_sel_valid),
    .sel_q_reg(txq_sel_queue)
  );

  svqc_safilt u_safilt (
    .clk_sys(clk_sys),
    .rst(rst),
    .mac1({sa1_high_reg, sa1_mid_reg, sa1_low_reg}),
    .mac2({sa2_high_reg, sa2_mid_reg, sa2_low_reg}),
    .sa_valid(sa_valid),
    .sa_addr(sa_addr),
    .sa_done_reg(sa_done),
    .sa_hit_reg(sa_hit)
  );

  // last match result kept for software; new compare overwrites it
  always_ff @(posedge clk_sys) begin
    if (rst) sa_last_reg <= 2'h0;
    else if (sa_done) sa_last_reg <= sa_hit;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_WAIT_FIRST: assert property (
    @(posedge clk_sys) disable iff (rst)
    (req && !ack_reg) |-> avs_waitrequest ##1 (!req || !avs_waitrequest)
  ) else $error("waitrequest sequence wrong");

  AST_CTRL_RO: assert property ( // RULE5
    @(posedge clk_sys) disable iff (rst)
    (avs_read && ack_reg && avs_address == byte_addr(IDX_CTRL))
      |-> avs_readdata[15:11] == 5'h00
  ) else $error("control upper bits not zero");

  AST_FWD_MASK: assert property ( // RULE1
    @(posedge clk_sys) disable iff (rst)
    bad_vid_valid |=> bad_vid_out_valid &&
      bad_vid_fwd_mask == $past(fwd_mask_reg)
  ) else $error("invalid-VID mask not forwarded");

  AST_INS_P1P2: assert property ( // RULE3
    @(posedge clk_sys) disable iff (rst)
    (fwd_valid && fwd_untagged && fwd_src_port == 2'h1
      && fwd_dst_port == 2'h2) |=> fwd_insert_tag == $past(ins_en_reg[0])
  ) else $error("port 1 to 2 insertion wrong");

  AST_Q_RESET: assert property ( // RULE13
    @(posedge clk_sys)
    rst |=> (q32_reg == Q32_RST && q10_reg == Q10_RST)
  ) else $error("queue registers not at reset value");

  AST_SA1_WRITE: assert property ( // RULE6
    @(posedge clk_sys) disable iff (rst)
    (wr_go && avs_address == byte_addr(IDX_SA1_LOW)
      && avs_byteenable[1:0] == 2'h3)
      |=> sa1_low_reg == $past(avs_writedata[15:0])
  ) else $error("filter word write lost");
endmodule : svqc_top
`default_nettype wire

// [dv/tb_top.sv]
// tb_top: self-checking bench of the switch configuration bank.
// assumes svqc_pkg and svqc_top are compiled first; drives every port.
`timescale 1ns/100ps
`default_nettype none
module tb_top import svqc_pkg::*; ();
  // ----------------------------------------------------------------------
  // signals and instance
  // ----------------------------------------------------------------------
  // short period keeps credit refills inside a short run
  localparam int PC = 20;
  logic clk_sys, rst;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable, txq_pending;
  logic bad_vid_valid, bad_vid_out_valid, fwd_valid, fwd_untagged;
  logic [2:0] bad_vid_fwd_mask;
  logic [1:0] fwd_src_port, fwd_dst_port, txq_sel_queue, sa_hit;
  logic fwd_out_valid, fwd_insert_tag, txq_take, txq_sel_valid;
  logic sa_valid, sa_done;
  logic [47:0] sa_addr;
  int num_errors, check_count;
  int sc [4];
  logic [7:0] ridx [9] = '{IDX_CTRL, IDX_SA1_LOW, IDX_SA1_MID, IDX_SA1_HIGH,
    IDX_SA2_LOW, IDX_SA2_MID, IDX_SA2_HIGH, IDX_Q32, IDX_Q10};
  logic [15:0] rrst [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h8488, 16'h8182};
  logic [15:0] swd [6] = '{16'h5566, 16'h3344, 16'h1122, 16'hE5F6,
    16'hC3D4, 16'hA1B2};
  logic [1:0] psrc [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [1:0] pdst [6] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h1, 2'h2};

  svqc_top #(.PCYC(PC)) svqc_top_inst (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bad_vid_valid(bad_vid_valid), .bad_vid_out_valid(bad_vid_out_valid),
    .bad_vid_fwd_mask(bad_vid_fwd_mask), .fwd_valid(fwd_valid),
    .fwd_src_port(fwd_src_port), .fwd_dst_port(fwd_dst_port),
    .fwd_untagged(fwd_untagged), .fwd_out_valid(fwd_out_valid),
    .fwd_insert_tag(fwd_insert_tag), .txq_pending(txq_pending),
    .txq_take(txq_take), .txq_sel_valid(txq_sel_valid),
    .txq_sel_queue(txq_sel_queue), .sa_valid(sa_valid),
    .sa_addr(sa_addr), .sa_done(sa_done), .sa_hit(sa_hit)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task test_done;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // request held until the edge after waitrequest is seen low
  task bus(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    logic w;
    int n;
    w = 1'b1;
    n = 0;
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= 4'h3;
    while (w !== 1'b0 && n < 50) begin
      #1;
      // read data taken with the waitrequest that closes the access
      w = avs_waitrequest;
      rd = avs_readdata;
      @(posedge clk_sys);
      n++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w !== 1'b0) begin
      num_errors++;
      test_done;
    end
  endtask : bus

  task rdchk(input logic [7:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0000);
    check(rd, {32'h0000_0000, exp});
  endtask : rdchk

  // one-cycle strobe; returns while its answer pulse stands
  task strobe(input int k, input logic [1:0] s, input logic [1:0] d,
              input logic u, input logic [47:0] a);
    @(posedge clk_sys);
    fwd_src_port <= s;
    fwd_dst_port <= d;
    fwd_untagged <= u;
    sa_addr <= a;
    bad_vid_valid <= (k == 0);
    fwd_valid <= (k == 1);
    sa_valid <= (k == 2);
    @(posedge clk_sys);
    bad_vid_valid <= 1'b0;
    fwd_valid <= 1'b0;
    sa_valid <= 1'b0;
    #1;
  endtask : strobe

  // takes every third cycle while a queue is offered; counts per queue
  task sched(input logic [3:0] pend, input int cyc);
    logic v, tk;
    logic [1:0] q;
    tk = 1'b0;
    for (int i = 0; i < 4; i++) sc[i] = 0;
    @(posedge clk_sys);
    txq_pending <= pend;
    // wait past one refill so new ratios are loaded
    repeat (PC + 2) @(posedge clk_sys);
    #1;
    v = txq_sel_valid;
    q = txq_sel_queue;
    repeat (cyc) begin
      @(posedge clk_sys);
      tk = !tk && (v === 1'b1);
      txq_take <= tk;
      #1;
      v = txq_sel_valid;
      q = txq_sel_queue;
      // a take only counts against the queue offered in the same cycle
      if (tk && v === 1'b1) sc[q]++;
    end
    @(posedge clk_sys);
    txq_take <= 1'b0;
    txq_pending <= 4'h0;
  endtask : sched

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    {avs_read, avs_write, bad_vid_valid, fwd_valid, fwd_untagged} = '0;
    {txq_take, sa_valid, txq_pending, avs_byteenable} = '0;
    avs_address = '0;
    avs_writedata = '0;
    fwd_src_port = 2'h0;
    fwd_dst_port = 2'h0;
    sa_addr = '0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rdchk(ridx[i], rrst[i]);
    bus(1'b1, 8'hBC, 16'hFFFF);
    rdchk(8'hBC, 16'h0000);
    bus(1'b1, IDX_CTRL, 16'hFFFF);
    rdchk(IDX_CTRL, 16'h07FF);
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, IDX_CTRL, 16'h0100 << m);
      strobe(0, 2'h0, 2'h0, 1'b0, 48'h0);
      check(bad_vid_out_valid, 1'b1);
      check(bad_vid_fwd_mask, 3'h1 << m);
    end
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, IDX_CTRL, 16'h0001 << i);
      for (int j = 0; j < 6; j++) begin
        strobe(1, psrc[j], pdst[j], 1'b1, 48'h0);
        check(fwd_out_valid, 1'b1);
        check(fwd_insert_tag, i == j);
      end
      // a frame that already carries a tag never gets another
      strobe(1, psrc[i], pdst[i], 1'b0, 48'h0);
      check(fwd_insert_tag, 1'b0);
    end
    for (int i = 0; i < 6; i++) bus(1'b1, ridx[i + 1], swd[i]);
    for (int i = 0; i < 6; i++) rdchk(ridx[i + 1], swd[i]);
    strobe(2, 2'h0, 2'h0, 1'b0, 48'h1122_3344_5566);
    check({sa_done, sa_hit}, 3'h5);
    rdchk(IDX_STATUS, 16'h0008);
    strobe(2, 2'h0, 2'h0, 1'b0, 48'hA1B2_C3D4_E5F6);
    check({sa_done, sa_hit}, 3'h6);
    strobe(2, 2'h0, 2'h0, 1'b0, 48'h1122_3344_5567);
    check({sa_done, sa_hit}, 3'h4);
    bus(1'b1, IDX_Q32, 16'h0408);
    sched(4'hC, 20);
    check(sc[2], 0);
    check(sc[3] > 3, 1'b1);
    bus(1'b1, IDX_Q32, 16'h0481);
    sched(4'hC, 2 * PC);
    check(sc[3] >= 1 && sc[3] <= 3, 1'b1);
    check(sc[2] > 0, 1'b1);
    bus(1'b1, IDX_Q32, 16'h0480);
    sched(4'h8, 20);
    check(sc[3], 0);
    bus(1'b1, IDX_Q32, 16'h8208);
    sched(4'h4, 2 * PC);
    check(sc[2] >= 2 && sc[2] <= 6, 1'b1);
    bus(1'b1, IDX_Q10, 16'h8102);
    sched(4'h3, 20);
    check(sc[0], 0);
    check(sc[1] > 3, 1'b1);
    // reset in mid-run brings back the queue, control and filter address 2 high word defaults
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(IDX_Q32, 16'h8488);
    rdchk(IDX_Q10, 16'h8182);
    rdchk(IDX_CTRL, 16'h0000);
    rdchk(IDX_SA2_HIGH, 16'h0000);
    test_done;
  end
endmodule : tb_top
`default_nettype wire
